/* File: rtl/frame_collector.sv */
`timescale 1ns/100ps
`include "mci_params.svh"
module frame_collector (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Byte stream
	input wire logic push,
	input wire logic [7:0] byte_in,
	input wire logic clr,
	// Frame fields
	output logic full,
	output logic sum_ok,
	output logic [7:0] addr,
	output logic [7:0] ins,
	output logic [7:0] typ,
	output logic [7:0] bank,
	output logic [31:0] value
);
	mci_pkg::coll_s st_ff;
	mci_pkg::coll_s nxt_st;
	logic [7:0] sum;

	always_comb begin
		sum = 8'h00;
		for (int i = 0; i < 8; i++) begin
			sum = sum + st_ff.hdr[i];
		end
		nxt_st = st_ff;
		if (clr) begin
			nxt_st.cnt = 4'h0;
		end else if (push && !full) begin
			if (st_ff.cnt == `FRAME_LEN - 4'h1) begin
				nxt_st.sum_ok = (byte_in == sum);
			end else begin
				nxt_st.hdr[3'h7 - st_ff.cnt[2:0]] = byte_in;
			end
			nxt_st.cnt = st_ff.cnt + 4'h1;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign full = (st_ff.cnt == `FRAME_LEN);
	assign sum_ok = st_ff.sum_ok;
	assign addr = st_ff.hdr[7];
	assign ins = st_ff.hdr[6];
	assign typ = st_ff.hdr[5];
	assign bank = st_ff.hdr[4];
	// Most significant byte arrives first
	assign value = st_ff.hdr[3:0];

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	a_frame_fill: assert property (
		push && !full && !clr && st_ff.cnt == 4'h8 |=> full)
		else $error("ninth byte did not complete the frame");

	a_sum_flag: assert property (
		push && !full && !clr && st_ff.cnt == 4'h8 |=>
		sum_ok == ($past(byte_in) == 8'(addr + ins + typ + bank
		+ value[31:24] + value[23:16] + value[15:8] + value[7:0])))
		else $error("checksum flag disagrees with frame bytes");
endmodule

/* File: rtl/mci_params.svh */
`ifndef MCI_PARAMS_SVH
`define MCI_PARAMS_SVH
`define FRAME_ADDR 8'h01
`define FRAME_LEN 4'h9
`define INS_ROR 8'h01
`define INS_ROL 8'h02
`define INS_MST 8'h03
`define INS_MVP 8'h04
`define INS_SAP 8'h05
`define INS_GAP 8'h06
`define MV_ABS 8'h00
`define MV_REL 8'h01
`define MV_PT 8'h02
`define PT_LAST 32'h00000014
`define RC_OK 8'h64
`define RC_SUM 8'h01
`define RC_CMD 8'h02
`define RC_TYPE 8'h03
`define RC_BANK 8'h04
`define RC_VAL 8'h05
`define AP_TPOS 8'h00
`define AP_APOS 8'h01
`define AP_TVEL 8'h02
`define AP_VMAX 8'h04
`define AP_ACC 8'h05
`define AP_DEC 8'h11
`define REG_CMD 8'h00
`define REG_STAT 8'h04
`define REG_RCODE 8'h08
`define REG_RVAL 8'h0c
`define REG_CTRL 8'h10
`define REG_ACCU 8'h14
`define REG_PT_IDX 8'h18
`define REG_PT_DATA 8'h1c
`define REG_TPOS 8'h20
`define REG_TVEL 8'h24
`define STAT_RDY 0
`define STAT_SUM 1
`define STAT_OVR 2
`define STAT_VMODE 3
`define STAT_BUSY 4
`define CTRL_ALONE 0
`endif

/* File: rtl/mci_pkg.sv */
package mci_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_FETCH = 2'b10
	} fsm_e;
	typedef struct packed {
		logic [3:0] cnt;
		logic [7:0][7:0] hdr;
		logic sum_ok;
	} coll_s;
	typedef struct packed {
		fsm_e fsm;
		logic ack;
		logic [31:0] dat;
		logic rdy;
		logic sum_err;
		logic ovr;
		logic vmode;
		logic alone;
		logic start;
		logic is_gap;
		logic [7:0] rcode;
		logic [31:0] rval;
		logic [31:0] accu;
		logic [4:0] pt_idx;
		logic [31:0] tpos;
		logic [31:0] tvel;
		logic [31:0] vmax;
		logic [31:0] accel;
		logic [31:0] decel;
		logic [31:0] diff;
	} mci_s;
endpackage

/* File: rtl/motion_command_interpreter.sv */
// Design decisions made here: the register addresses and the Wishbone slave port.
`timescale 1ns/100ps
`include "mci_params.svh"
module motion_command_interpreter (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Wishbone classic slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Ramp generator side
	input wire logic [31:0] actual_pos,
	output logic [31:0] target_pos,
	output logic [31:0] target_vel,
	output logic vel_mode,
	output logic move_start,
	output logic [31:0] pos_diff,
	output logic [31:0] max_pos_speed,
	output logic [31:0] accel,
	output logic [31:0] decel
);
	mci_pkg::mci_s st_ff;
	mci_pkg::mci_s nxt_st;
	logic full;
	logic sum_ok;
	logic [7:0] f_addr;
	logic [7:0] f_ins;
	logic [7:0] f_typ;
	logic [7:0] f_bank;
	logic [31:0] f_val;
	logic [31:0] ap_rd;
	logic [31:0] pt_rd;
	logic ap_we;
	logic [7:0] ap_wa;
	logic [31:0] ap_wd;
	logic pt_we;
	logic bus_new;
	logic wr;
	logic idle;
	logic push;
	logic clr;
	logic go;
	logic reply;
	logic [7:0] code;
	logic [31:0] rv;
	logic [31:0] vel;
	logic [31:0] stat;

	assign bus_new = cyc_i && stb_i && !st_ff.ack;
	// Writes take effect on the edge that the master sees ack
	assign wr = cyc_i && stb_i && we_i && st_ff.ack;
	assign idle = (st_ff.fsm == mci_pkg::ST_IDLE);
	assign push = wr && adr_i == `REG_CMD && sel_i[0] && idle && !full;
	assign clr = idle && full;
	assign go = clr && f_addr == `FRAME_ADDR && sum_ok;

	frame_collector u_coll (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.push(push),
		.byte_in(dat_i[7:0]),
		.clr(clr),
		.full(full),
		.sum_ok(sum_ok),
		.addr(f_addr),
		.ins(f_ins),
		.typ(f_typ),
		.bank(f_bank),
		.value(f_val)
	);

	param_ram #(.AW(8), .DW(32)) u_axis (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.we(ap_we),
		.waddr(ap_wa),
		.wdata(ap_wd),
		.raddr(f_typ),
		.rdata(ap_rd)
	);

	param_ram #(.AW(5), .DW(32)) u_points (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.we(pt_we),
		.waddr(st_ff.pt_idx),
		.wdata(dat_i),
		.raddr(f_val[4:0]),
		.rdata(pt_rd)
	);

	always_comb begin
		nxt_st = st_ff;
		ap_we = 1'b0;
		ap_wa = f_typ;
		ap_wd = f_val;
		pt_we = 1'b0;
		reply = 1'b0;
		code = `RC_OK;
		rv = 32'h0;
		vel = 32'h0;
		stat = 32'h0;
		stat[`STAT_RDY] = st_ff.rdy;
		stat[`STAT_SUM] = st_ff.sum_err;
		stat[`STAT_OVR] = st_ff.ovr;
		stat[`STAT_VMODE] = st_ff.vmode;
		stat[`STAT_BUSY] = !idle || full;
		nxt_st.start = 1'b0;
		nxt_st.ack = bus_new;
		nxt_st.diff = st_ff.tpos - actual_pos;

		if (bus_new) begin
			case (adr_i)
			`REG_STAT: nxt_st.dat = stat;
			`REG_RCODE: nxt_st.dat = {24'h0, st_ff.rcode};
			`REG_RVAL: nxt_st.dat = st_ff.rval;
			`REG_CTRL: nxt_st.dat = {31'h0, st_ff.alone};
			`REG_ACCU: nxt_st.dat = st_ff.accu;
			`REG_PT_IDX: nxt_st.dat = {27'h0, st_ff.pt_idx};
			`REG_TPOS: nxt_st.dat = st_ff.tpos;
			`REG_TVEL: nxt_st.dat = st_ff.tvel;
			default: nxt_st.dat = 32'h0;
			endcase
		end

		if (wr) begin
			case (adr_i)
			`REG_CMD: begin
				// A byte that arrives while a frame is being served is lost
				if (!push) begin
					nxt_st.ovr = 1'b1;
				end
			end
			`REG_STAT: begin
				if (sel_i[0]) begin
					if (dat_i[`STAT_RDY]) begin
						nxt_st.rdy = 1'b0;
					end
					if (dat_i[`STAT_SUM]) begin
						nxt_st.sum_err = 1'b0;
					end
					if (dat_i[`STAT_OVR] && !(st_ff.ack && push)) begin
						nxt_st.ovr = 1'b0;
					end
				end
			end
			`REG_CTRL: begin
				if (sel_i[0]) begin
					nxt_st.alone = dat_i[`CTRL_ALONE];
				end
			end
			`REG_PT_IDX: begin
				if (sel_i[0]) begin
					nxt_st.pt_idx = dat_i[4:0];
				end
			end
			`REG_PT_DATA: pt_we = (sel_i == 4'hf);
			default: ;
			endcase
		end

		unique case (st_ff.fsm)
		mci_pkg::ST_IDLE: begin
			if (go) begin
				reply = 1'b1;
				if (f_bank != 8'h00
					&& !(f_ins == `INS_MVP && f_typ == `MV_PT)) begin
					code = `RC_BANK;
				end else begin
					case (f_ins)
					`INS_ROR, `INS_ROL, `INS_MST: begin
						if (f_typ != 8'h00) begin
							code = `RC_TYPE;
						end else begin
							if (f_ins == `INS_ROR) begin
								vel = f_val;
							end else if (f_ins == `INS_ROL) begin
								vel = -f_val;
							end
							// Leaving positioning mode aborts any move
							nxt_st.vmode = 1'b1;
							nxt_st.tvel = vel;
							ap_we = 1'b1;
							ap_wa = `AP_TVEL;
							ap_wd = vel;
						end
					end
					`INS_MVP: begin
						case (f_typ)
						`MV_ABS, `MV_REL: begin
							if (f_typ == `MV_ABS) begin
								ap_wd = f_val;
							end else begin
								ap_wd = actual_pos + f_val;
							end
							nxt_st.tpos = ap_wd;
							ap_we = 1'b1;
							ap_wa = `AP_TPOS;
							nxt_st.vmode = 1'b0;
							nxt_st.start = 1'b1;
						end
						`MV_PT: begin
							if (f_val > `PT_LAST) begin
								code = `RC_VAL;
							end else begin
								reply = 1'b0;
								nxt_st.is_gap = 1'b0;
								nxt_st.fsm = mci_pkg::ST_FETCH;
							end
						end
						default: code = `RC_TYPE;
						endcase
					end
					`INS_SAP: begin
						ap_we = 1'b1;
						if (f_typ == `AP_TPOS) begin
							nxt_st.tpos = f_val;
						end
						if (f_typ == `AP_TVEL) begin
							nxt_st.tvel = f_val;
						end
						if (f_typ == `AP_VMAX) begin
							nxt_st.vmax = f_val;
						end
						if (f_typ == `AP_ACC) begin
							nxt_st.accel = f_val;
						end
						if (f_typ == `AP_DEC) begin
							nxt_st.decel = f_val;
						end
					end
					`INS_GAP: begin
						if (f_typ == `AP_APOS) begin
							rv = actual_pos;
							if (st_ff.alone) begin
								nxt_st.accu = actual_pos;
							end
						end else begin
							reply = 1'b0;
							nxt_st.is_gap = 1'b1;
							nxt_st.fsm = mci_pkg::ST_FETCH;
						end
					end
					default: code = `RC_CMD;
					endcase
				end
			end else if (clr && f_addr == `FRAME_ADDR) begin
				reply = 1'b1;
				code = `RC_SUM;
				nxt_st.sum_err = 1'b1;
			end
		end
		mci_pkg::ST_FETCH: begin
			// Stored word became readable this cycle
			reply = 1'b1;
			nxt_st.fsm = mci_pkg::ST_IDLE;
			if (st_ff.is_gap) begin
				rv = ap_rd;
				if (st_ff.alone) begin
					nxt_st.accu = ap_rd;
				end
			end else begin
				nxt_st.tpos = pt_rd;
				ap_we = 1'b1;
				ap_wa = `AP_TPOS;
				ap_wd = pt_rd;
				nxt_st.vmode = 1'b0;
				nxt_st.start = 1'b1;
			end
		end
		endcase

		// Hardware setting the reply flag wins over a software clear
		if (reply) begin
			nxt_st.rdy = 1'b1;
			nxt_st.rcode = code;
			nxt_st.rval = rv;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			st_ff <= '0;
			st_ff.fsm <= mci_pkg::ST_IDLE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign dat_o = st_ff.dat;
	assign ack_o = st_ff.ack;
	assign target_pos = st_ff.tpos;
	assign target_vel = st_ff.tvel;
	assign vel_mode = st_ff.vmode;
	assign move_start = st_ff.start;
	assign pos_diff = st_ff.diff;
	assign max_pos_speed = st_ff.vmax;
	assign accel = st_ff.accel;
	assign decel = st_ff.decel;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	logic plain;
	assign plain = go && f_bank == 8'h00 && f_typ == 8'h00;

	sequence s_pt_fetch;
		st_ff.fsm == mci_pkg::ST_FETCH ##1 (move_start && st_ff.rdy);
	endsequence

	a_rol_velocity: assert property (
		plain && f_ins == `INS_ROL |=>
		vel_mode && target_vel == -$past(f_val))
		else $error("rotate left did not load negated velocity");

	a_ror_velocity: assert property (
		plain && f_ins == `INS_ROR |=>
		vel_mode && target_vel == $past(f_val))
		else $error("rotate right did not load velocity");

	a_stop_zero: assert property (
		plain && f_ins == `INS_MST |=>
		vel_mode && target_vel == 32'h0 && !move_start)
		else $error("stop did not zero the velocity");

	a_reply_ok: assert property (
		plain && (f_ins == `INS_ROR || f_ins == `INS_MST) |=>
		st_ff.rdy && st_ff.rcode == `RC_OK)
		else $error("accepted command gave no OK reply");

	a_abs_target: assert property (
		plain && f_ins == `INS_MVP |=>
		move_start && !vel_mode && target_pos == $past(f_val))
		else $error("absolute move target wrong");

	a_rel_target: assert property (
		go && f_bank == 8'h00 && f_ins == `INS_MVP
		&& f_typ == `MV_REL |=>
		target_pos == $past(actual_pos) + $past(f_val))
		else $error("relative move target wrong");

	a_point_move: assert property (
		go && f_ins == `INS_MVP && f_typ == `MV_PT
		&& f_val <= `PT_LAST |=> s_pt_fetch)
		else $error("point move did not start after fetch");

	a_diff_wrap: assert property (
		move_start |=> pos_diff == target_pos - $past(actual_pos))
		else $error("position difference not wrapped");

	a_sap_reply: assert property (
		go && f_bank == 8'h00 && f_ins == `INS_SAP
		&& f_typ == `AP_VMAX |=>
		max_pos_speed == $past(f_val) && st_ff.rcode == `RC_OK)
		else $error("set parameter not applied");

	a_gap_accu: assert property (
		go && f_bank == 8'h00 && f_ins == `INS_GAP
		&& f_typ != `AP_APOS && !st_ff.alone |-> ##2
		(st_ff.rdy && st_ff.accu == $past(st_ff.accu, 2)
		&& st_ff.rval == $past(ap_rd)))
		else $error("get parameter reply or accumulator wrong");

	a_bad_sum: assert property (
		clr && f_addr == `FRAME_ADDR && !sum_ok |=>
		st_ff.rcode == `RC_SUM && st_ff.sum_err && !move_start)
		else $error("bad checksum not reported");
endmodule

/* File: rtl/param_ram.sv */
`timescale 1ns/100ps
module param_ram #(
	parameter int AW = 8,
	parameter int DW = 32
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Write port
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	// Read port, one cycle latency
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata
);
	// No reset on the array: contents are lost with power, like SRAM
	logic [DW-1:0] mem [2**AW];

	always_ff @(posedge sys_clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rdata <= '0;
		end else begin
			rdata <= mem[raddr];
		end
	end
endmodule

/* File: verification/ramp_model.sv */
`timescale 1ns/100ps
module ramp_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Bench control
	input wire logic run,
	input wire logic pre_en,
	input wire logic [31:0] pre_val,
	// From the interpreter
	input wire logic vel_mode,
	input wire logic [31:0] target_vel,
	input wire logic [31:0] pos_diff,
	// Position feedback
	output logic [31:0] actual_pos
);
	function automatic logic [31:0] step(input logic [31:0] v);
		if (v == 32'h0) begin
			return 32'h0;
		end
		return v[31] ? 32'hffffffff : 32'h1;
	endfunction

	// Held still unless the bench lets it run or presets it, so targets stay predictable
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			actual_pos <= 32'h0;
		end else if (pre_en) begin
			actual_pos <= pre_val;
		end else if (run && vel_mode) begin
			actual_pos <= actual_pos + step(target_vel);
		end else if (run) begin
			// Sign of the wrapped difference picks the shorter way
			actual_pos <= actual_pos + step(pos_diff);
		end
	end
endmodule

/* File: verification/tb_top.sv */
`timescale 1ns/100ps
`include "mci_params.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
	n_fail++; $display("mismatch %s exp %h got %h", n, (e), (g)); end end
module tb_top;
	logic sys_clk = 1'h0, resetn = 1'h0, cyc_i = 1'h0, stb_i = 1'h0;
	logic we_i = 1'h0, ack_o, vel_mode, move_start, run = 1'h0;
	logic pre_en = 1'h0;
	logic [7:0] adr_i = 8'h0;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0, dat_o, actual_pos, target_pos, target_vel;
	logic [31:0] pos_diff, max_pos_speed, accel, decel, q, t;
	logic [31:0] pre_val = 32'h0;
	int n_fail = 0, checks_done = 0, n_mv = 0, m0;

	motion_command_interpreter uut (.sys_clk(sys_clk), .resetn(resetn),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.actual_pos(actual_pos), .target_pos(target_pos),
		.target_vel(target_vel), .vel_mode(vel_mode),
		.move_start(move_start), .pos_diff(pos_diff),
		.max_pos_speed(max_pos_speed), .accel(accel), .decel(decel));
	ramp_model ramp (.sys_clk(sys_clk), .resetn(resetn), .run(run),
		.pre_en(pre_en), .pre_val(pre_val), .vel_mode(vel_mode),
		.target_vel(target_vel), .pos_diff(pos_diff),
		.actual_pos(actual_pos));

	initial begin
		forever #25 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (move_start === 1'h1) begin
			n_mv++;
		end
	end

	task automatic print_verdict;
		if (n_fail == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Classic cycle: hold everything until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= 4'hf;
		do begin
			@(posedge sys_clk);
			n++;
		end while (ack_o !== 1'h1 && n < 50);
		q = dat_o;
		if (n >= 50) begin
			n_fail++;
		end
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
	endtask

	// A zero expected code means no reply may appear at all
	task automatic frame(input logic [7:0] ad, ins, ty, bk,
		input logic [31:0] v, input logic [7:0] bad, rc);
		logic [7:0] b[9];
		b = '{ad, ins, ty, bk, v[31:24], v[23:16], v[15:8], v[7:0], 8'h0};
		for (int i = 0; i < 8; i++) begin
			b[8] += b[i];
		end
		b[8] ^= bad;
		for (int i = 0; i < 9; i++) begin
			wb(1'h1, `REG_CMD, {24'h0, b[i]});
		end
		for (int i = 0; i < 8; i++) begin
			wb(1'h0, `REG_STAT, 32'h0);
			if (q[`STAT_RDY] === 1'h1) begin
				break;
			end
		end
		if (rc == 8'h0) begin
			`CHK("reply", 1'h0, q[`STAT_RDY])
		end else begin
			wb(1'h0, `REG_RCODE, 32'h0);
			`CHK("rcode", rc, q[7:0])
			wb(1'h1, `REG_STAT, 32'h7);
		end
	endtask

	initial begin
		#1000000;
		n_fail++;
		print_verdict;
	end

	initial begin
		repeat (3) @(posedge sys_clk);
		resetn <= 1'h1;
		wb(1'h0, `REG_STAT, 32'h0);
		`CHK("stat", 32'h0, q)
		frame(`FRAME_ADDR, `INS_ROL, 8'h0, 8'h0, 32'hc800, 8'h0, `RC_OK);
		`CHK("tvel", 32'hffff3800, target_vel)
		`CHK("vmode", 1'h1, vel_mode)
		frame(`FRAME_ADDR, `INS_ROR, 8'h0, 8'h0, 32'hc800, 8'h0, `RC_OK);
		`CHK("tvel", 32'hc800, target_vel)
		frame(`FRAME_ADDR, `INS_SAP, `AP_VMAX, 8'h0, 32'hc800, 8'h0, `RC_OK);
		frame(`FRAME_ADDR, `INS_SAP, `AP_ACC, 8'h0, 32'h1f4, 8'h0, `RC_OK);
		frame(`FRAME_ADDR, `INS_SAP, `AP_DEC, 8'h0, 32'h2bc, 8'h0, `RC_OK);
		`CHK("vmax", 32'hc800, max_pos_speed)
		`CHK("acc", 32'h1f4, accel)
		`CHK("dec", 32'h2bc, decel)
		m0 = n_mv;
		frame(`FRAME_ADDR, `INS_MVP, `MV_ABS, 8'h0, 32'h15f90, 8'h0, `RC_OK);
		`CHK("tpos", 32'h15f90, target_pos)
		`CHK("vmode", 1'h0, vel_mode)
		`CHK("start", m0 + 1, n_mv)
		`CHK("diff", 32'h15f90 - actual_pos, pos_diff)
		run <= 1'h1;
		repeat (20) @(posedge sys_clk);
		frame(`FRAME_ADDR, `INS_MST, 8'h0, 8'h0, 32'h0, 8'h0, `RC_OK);
		run <= 1'h0;
		`CHK("tvel", 32'h0, target_vel)
		`CHK("vmode", 1'h1, vel_mode)
		t = actual_pos;
		frame(`FRAME_ADDR, `INS_MVP, `MV_REL, 8'h0, 32'hffffd8f0, 8'h0, `RC_OK);
		`CHK("tpos", t + 32'hffffd8f0, target_pos)
		wb(1'h1, `REG_PT_IDX, 32'h8);
		wb(1'h1, `REG_PT_DATA, 32'h12345678);
		frame(`FRAME_ADDR, `INS_MVP, `MV_PT, 8'h0, 32'h8, 8'h0, `RC_OK);
		`CHK("tpos", 32'h12345678, target_pos)
		frame(`FRAME_ADDR, `INS_MVP, `MV_PT, 8'h0, 32'h15, 8'h0, `RC_VAL);
		pre_val <= 32'hfffffff6;
		pre_en <= 1'h1;
		@(posedge sys_clk);
		pre_en <= 1'h0;
		frame(`FRAME_ADDR, `INS_MVP, `MV_ABS, 8'h0, 32'h7fffffff, 8'h0, `RC_OK);
		`CHK("diff", 32'h80000009, pos_diff)
		frame(`FRAME_ADDR, `INS_GAP, `AP_VMAX, 8'h0, 32'h0, 8'h0, `RC_OK);
		wb(1'h0, `REG_RVAL, 32'h0);
		`CHK("rval", 32'hc800, q)
		wb(1'h0, `REG_ACCU, 32'h0);
		`CHK("accu", 32'h0, q)
		wb(1'h1, `REG_CTRL, 32'h1);
		frame(`FRAME_ADDR, `INS_GAP, `AP_VMAX, 8'h0, 32'h0, 8'h0, `RC_OK);
		wb(1'h0, `REG_ACCU, 32'h0);
		`CHK("accu", 32'hc800, q)
		frame(`FRAME_ADDR, `INS_ROL, 8'h0, 8'h0, 32'h1, 8'h1, `RC_SUM);
		frame(8'h02, `INS_ROL, 8'h0, 8'h0, 32'h1, 8'h0, 8'h0);
		frame(`FRAME_ADDR, 8'h07, 8'h0, 8'h0, 32'h0, 8'h0, `RC_CMD);
		frame(`FRAME_ADDR, `INS_ROL, 8'h1, 8'h0, 32'h1, 8'h0, `RC_TYPE);
		frame(`FRAME_ADDR, `INS_MST, 8'h0, 8'h1, 32'h0, 8'h0, `RC_BANK);
		wb(1'h0, 8'h40, 32'h0);
		`CHK("unmapped", 32'h0, q)
		print_verdict;
	end
endmodule
